/* File: inc/clkgen_pkg.sv */
// shared constants and types of the system clock and prescaler block
`default_nettype none
package clkgen_pkg;

   // prescaler and peripheral taps
   localparam int unsigned PRESC_WIDTH   = 13;
   localparam int unsigned MAX_MODULES   = 8;
   localparam int unsigned TAP_SEL_WIDTH = 4;
   localparam logic [3:0]  TAP_LAST      = 4'hc;

   // register byte offsets
   localparam logic [7:0] OFS_SYS_ONE  = 8'h00;
   localparam logic [7:0] OFS_SYS_TWO  = 8'h04;
   localparam logic [7:0] OFS_MOD_STBY = 8'h08;
   localparam logic [7:0] OFS_TAP_SEL  = 8'h0c;
   localparam logic [7:0] OFS_STATUS   = 8'h10;

   // register indices after address decode
   localparam logic [2:0] IDX_NONE     = 3'h0;
   localparam logic [2:0] IDX_SYS_ONE  = 3'h1;
   localparam logic [2:0] IDX_SYS_TWO  = 3'h2;
   localparam logic [2:0] IDX_MOD_STBY = 3'h3;
   localparam logic [2:0] IDX_TAP_SEL  = 3'h4;
   localparam logic [2:0] IDX_STATUS   = 3'h5;

   // field positions
   localparam int unsigned STBY_SEL_POS  = 7;
   localparam int unsigned WAIT_SEL_LSB  = 4;
   localparam int unsigned SUBSLEEP_POS  = 3;
   localparam int unsigned DIV_FIELD_LSB = 0;

   // values after reset
   localparam logic [7:0]  SYS_ONE_RST  = 8'h00;
   localparam logic [7:0]  SYS_TWO_RST  = 8'h00;
   localparam logic [7:0]  MOD_STBY_RST = 8'h00;
   localparam logic [31:0] TAP_SEL_RST  = 32'h00000000;

   // system clock division codes and their counter masks
   localparam logic [2:0] DIV_OSC = 3'h0;
   localparam logic [2:0] DIV_8   = 3'h1;
   localparam logic [2:0] DIV_16  = 3'h2;
   localparam logic [2:0] DIV_32  = 3'h3;
   localparam logic [5:0] MASK_1  = 6'h00;
   localparam logic [5:0] MASK_8  = 6'h07;
   localparam logic [5:0] MASK_16 = 6'h0f;
   localparam logic [5:0] MASK_32 = 6'h1f;
   localparam logic [5:0] MASK_64 = 6'h3f;

   // standby wake wait in states, indexed by the wait select code
   localparam int unsigned WAIT_WIDTH = 18;
   localparam logic [7:0][WAIT_WIDTH-1:0] WAIT_TABLE = {
      18'h00010, 18'h00080, 18'h00400, 18'h20000,
      18'h10000, 18'h08000, 18'h04000, 18'h02000};

   typedef enum logic [2:0] {
      MODE_ACTIVE,
      MODE_SLEEP,
      MODE_STANDBY,
      MODE_SUBSLEEP,
      MODE_WAKE
   } mode_t;

endpackage : clkgen_pkg
`default_nettype wire

/* File: inc/presc_if.sv */
// link between the clock controller and the prescaler counter
`timescale 1ns/1ps
`default_nettype none
interface presc_if #(
   parameter int unsigned WIDTH = clkgen_pkg::PRESC_WIDTH
);
   logic             step;
   logic             clear;
   logic [WIDTH-1:0] tapPulse;

   modport ctrl (output step, output clear, input tapPulse);
   modport cnt  (input step, input clear, output tapPulse);
endinterface : presc_if
`default_nettype wire

/* File: core/presc_counter.sv */
// free-running prescaler counter with divided tap pulses
`timescale 1ns/1ps
`default_nettype none
module presc_counter #(
   parameter int unsigned WIDTH = clkgen_pkg::PRESC_WIDTH
) (
   input wire logic clk,
   input wire logic arst_n,
   presc_if.cnt     link
);

   logic [WIDTH-1:0] count_q;

   // clear wins over step so a stopped clock never leaves a stale count
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         count_q <= '0;
      end else if (link.clear) begin
         count_q <= '0;
      end else if (link.step) begin
         count_q <= count_q + 1'b1;
      end
   end

   // tap i fires once every 2^(i+1) steps
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_tap
         assign link.tapPulse[i] = link.step & (&count_q[i:0]);
      end
   endgenerate

endmodule : presc_counter
`default_nettype wire

/* File: core/sysclk_ctrl.sv */
// system clock generator, prescaler taps and power mode control
//
// Operation
// - the peripheral prescaler is a 13-bit up counter on the system clock.
// - it advances by one for each system clock period while running.
// - reset clears it to zero and counting starts once reset is left.
// - standby and subsleep stop the system clock and clear the prescaler.
// - software can neither read nor write the prescaler value.
// - taps from system clock over 2 up to over 8192 go to the peripherals.
// - each peripheral picks its own tap, independent of the others.
// - in active and sleep the division field picks the prescaler input.
// - active runs all on a clock of osc, osc/8, /16, /32 or /64.
// - sleep halts the cpu clock while peripherals keep the system clock.
// - standby halts the cpu and every peripheral clock.
// - subsleep halts everything and holds the port output states.
// - module standby halts single unused peripherals in any mode.
// - on sleep, standby select 0 goes to sleep and 1 to standby, or to subsleep with the subsleep bit set.
// - wake from standby waits the states given by the wait select code.
//
// Implementation choices: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module sysclk_ctrl #(
   parameter int unsigned MOD_COUNT = clkgen_pkg::MAX_MODULES,
   parameter logic [7:0][clkgen_pkg::WAIT_WIDTH-1:0] WAIT_STATES =
      clkgen_pkg::WAIT_TABLE
) (
   input  wire logic                 clk,
   input  wire logic                 arst_n,
   // ahb-lite slave
   input  wire logic                 hsel,
   input  wire logic [31:0]          haddr,
   input  wire logic [1:0]           htrans,
   input  wire logic                 hwrite,
   input  wire logic [2:0]           hsize,
   input  wire logic [31:0]          hwdata,
   input  wire logic                 hready,
   output logic                      hreadyout,
   output logic                      hresp,
   output logic [31:0]               hrdata,
   // cpu sleep instruction and wake event
   input  wire logic                 sleepReq,
   input  wire logic                 wakeReq,
   // clock enables towards cpu and peripherals
   output logic                      sysClkEn,
   output logic                      cpuClkEn,
   output logic [MOD_COUNT-1:0]      periphClkEn,
   output logic [MOD_COUNT-1:0]      periphTick,
   output logic                      ioHold
);

   localparam int unsigned PW = clkgen_pkg::PRESC_WIDTH;
   localparam int unsigned WW = clkgen_pkg::WAIT_WIDTH;
   localparam int unsigned SW = clkgen_pkg::TAP_SEL_WIDTH;

   // bus side
   logic                   addrValid;
   logic [2:0]             rdIdx;
   logic [2:0]             wrIdx;
   logic                   wrPend_q;
   logic [7:0]             wrAddr_q;
   logic [31:0]            rdWord;
   logic [31:0]            hrdata_q;

   // software registers
   logic [7:0]             sysOne_q;
   logic [7:0]             sysTwo_q;
   logic [7:0]             modStby_q;
   logic [31:0]            tapSel_q;

   // mode control
   clkgen_pkg::mode_t      mode_q;
   clkgen_pkg::mode_t      sleepTarget;
   logic [WW-1:0]          waitCnt_q;
   logic [2:0]             waitSel;
   logic                   stbySel;
   logic                   subSel;
   logic [2:0]             divCode;

   // clock generation
   logic                   genRun;
   logic                   prescRun;
   logic                   periphRun;
   logic [5:0]             divCnt_q;
   logic [5:0]             divMaskNow;
   logic                   sysEn;

   // registered outputs
   logic                   sysClkEn_q;
   logic                   cpuClkEn_q;
   logic [MOD_COUNT-1:0]   periphClkEn_q;
   logic [MOD_COUNT-1:0]   periphTick_q;
   logic                   ioHold_q;

   presc_if #(.WIDTH(PW)) presc ();

   // byte offset to register index, shared by read and write paths
   function automatic logic [2:0] regIndex(input logic [7:0] ofs);
      logic [2:0] idx;
      idx = clkgen_pkg::IDX_NONE;
      unique case (ofs)
         clkgen_pkg::OFS_SYS_ONE:  idx = clkgen_pkg::IDX_SYS_ONE;
         clkgen_pkg::OFS_SYS_TWO:  idx = clkgen_pkg::IDX_SYS_TWO;
         clkgen_pkg::OFS_MOD_STBY: idx = clkgen_pkg::IDX_MOD_STBY;
         clkgen_pkg::OFS_TAP_SEL:  idx = clkgen_pkg::IDX_TAP_SEL;
         clkgen_pkg::OFS_STATUS:   idx = clkgen_pkg::IDX_STATUS;
         default:                  idx = clkgen_pkg::IDX_NONE;
      endcase
      return idx;
   endfunction : regIndex

   // division code to divider mask; spare codes fall back to /64
   function automatic logic [5:0] divMask(input logic [2:0] code);
      logic [5:0] m;
      m = clkgen_pkg::MASK_64;
      unique case (code)
         clkgen_pkg::DIV_OSC: m = clkgen_pkg::MASK_1;
         clkgen_pkg::DIV_8:   m = clkgen_pkg::MASK_8;
         clkgen_pkg::DIV_16:  m = clkgen_pkg::MASK_16;
         clkgen_pkg::DIV_32:  m = clkgen_pkg::MASK_32;
         default:             m = clkgen_pkg::MASK_64;
      endcase
      return m;
   endfunction : divMask

   // tap select to tap bit; codes past the last tap clamp to /8192
   function automatic logic tapOf(input logic [SW-1:0] sel,
                                  input logic [PW-1:0] taps);
      logic [SW-1:0] s;
      s = (sel > clkgen_pkg::TAP_LAST) ? clkgen_pkg::TAP_LAST : sel;
      return taps[s];
   endfunction : tapOf

   // ahb-lite slave, zero wait states, always okay
   assign addrValid = hsel & htrans[1] & hready;
   assign rdIdx     = regIndex(haddr[7:0]);
   assign wrIdx     = regIndex(wrAddr_q);

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         wrPend_q <= 1'b0;
         wrAddr_q <= 8'h00;
      end else begin
         wrPend_q <= addrValid & hwrite;
         if (addrValid & hwrite) begin
            wrAddr_q <= haddr[7:0];
         end
      end
   end

   // the prescaler count has no address at all
   always_comb begin
      rdWord = 32'h00000000;
      unique case (rdIdx)
         clkgen_pkg::IDX_SYS_ONE:  rdWord[7:0] = sysOne_q;
         clkgen_pkg::IDX_SYS_TWO:  rdWord[7:0] = sysTwo_q;
         clkgen_pkg::IDX_MOD_STBY: rdWord[7:0] = modStby_q;
         clkgen_pkg::IDX_TAP_SEL:  rdWord = tapSel_q;
         clkgen_pkg::IDX_STATUS:   rdWord[2:0] = mode_q;
         default:                  rdWord = 32'h00000000;
      endcase
   end

   // read data is fetched in the address phase to stay zero-wait
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         hrdata_q <= 32'h00000000;
      end else if (addrValid & ~hwrite) begin
         hrdata_q <= rdWord;
      end
   end

   // software registers
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sysOne_q  <= clkgen_pkg::SYS_ONE_RST;
         sysTwo_q  <= clkgen_pkg::SYS_TWO_RST;
         modStby_q <= clkgen_pkg::MOD_STBY_RST;
         tapSel_q  <= clkgen_pkg::TAP_SEL_RST;
      end else if (wrPend_q) begin
         unique case (wrIdx)
            clkgen_pkg::IDX_SYS_ONE: begin
               sysOne_q <= {hwdata[7:4], 4'h0};
            end
            clkgen_pkg::IDX_SYS_TWO: begin
               sysTwo_q <= {4'h0, hwdata[3:0]};
            end
            clkgen_pkg::IDX_MOD_STBY: begin
               modStby_q <= hwdata[7:0];
            end
            clkgen_pkg::IDX_TAP_SEL: begin
               tapSel_q <= hwdata;
            end
            default: begin
               sysOne_q <= sysOne_q;
            end
         endcase
      end
   end

   assign stbySel = sysOne_q[clkgen_pkg::STBY_SEL_POS];
   assign waitSel = sysOne_q[clkgen_pkg::WAIT_SEL_LSB +: 3];
   assign subSel  = sysTwo_q[clkgen_pkg::SUBSLEEP_POS];
   assign divCode = sysTwo_q[clkgen_pkg::DIV_FIELD_LSB +: 3];

   // power mode sequencer
   always_comb begin
      if (!stbySel) begin
         sleepTarget = clkgen_pkg::MODE_SLEEP;
      end else if (subSel) begin
         sleepTarget = clkgen_pkg::MODE_SUBSLEEP;
      end else begin
         sleepTarget = clkgen_pkg::MODE_STANDBY;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         mode_q <= clkgen_pkg::MODE_ACTIVE;
      end else begin
         unique case (mode_q)
            clkgen_pkg::MODE_ACTIVE: begin
               if (sleepReq) begin
                  mode_q <= sleepTarget;
               end
            end
            clkgen_pkg::MODE_SLEEP: begin
               if (wakeReq) begin
                  mode_q <= clkgen_pkg::MODE_ACTIVE;
               end
            end
            clkgen_pkg::MODE_STANDBY,
            clkgen_pkg::MODE_SUBSLEEP: begin
               if (wakeReq) begin
                  mode_q <= clkgen_pkg::MODE_WAKE;
               end
            end
            clkgen_pkg::MODE_WAKE: begin
               if (waitCnt_q == '0) begin
                  mode_q <= clkgen_pkg::MODE_ACTIVE;
               end
            end
            default: begin
               mode_q <= clkgen_pkg::MODE_ACTIVE;
            end
         endcase
      end
   end

   // wake wait, loaded with count minus one so the total is exact
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         waitCnt_q <= '0;
      end else if (wakeReq && (mode_q == clkgen_pkg::MODE_STANDBY ||
                               mode_q == clkgen_pkg::MODE_SUBSLEEP)) begin
         waitCnt_q <= WAIT_STATES[waitSel] - 1'b1;
      end else if (mode_q == clkgen_pkg::MODE_WAKE && waitCnt_q != '0) begin
         waitCnt_q <= waitCnt_q - 1'b1;
      end
   end

   // system clock divider and prescaler
   // generator stops in standby and subsleep, restarts for the wake wait
   assign genRun    = (mode_q != clkgen_pkg::MODE_STANDBY) &&
                      (mode_q != clkgen_pkg::MODE_SUBSLEEP);
   assign prescRun  = (mode_q == clkgen_pkg::MODE_ACTIVE) ||
                      (mode_q == clkgen_pkg::MODE_SLEEP);
   assign periphRun = prescRun;
   assign divMaskNow = divMask(divCode);

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         divCnt_q <= 6'h00;
      end else if (!genRun) begin
         divCnt_q <= 6'h00;
      end else begin
         divCnt_q <= divCnt_q + 6'h01;
      end
   end

   // a new division code takes effect at once, no resync of the phase
   assign sysEn = genRun && ((divCnt_q & divMaskNow) == divMaskNow);

   assign presc.step  = sysEn & prescRun;
   assign presc.clear = ~prescRun;

   presc_counter #(
      .WIDTH (PW)
   ) u_presc (
      .clk    (clk),
      .arst_n (arst_n),
      .link   (presc.cnt)
   );

   // clock enables and per-module ticks
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sysClkEn_q <= 1'b0;
         cpuClkEn_q <= 1'b0;
         ioHold_q   <= 1'b0;
      end else begin
         sysClkEn_q <= sysEn;
         cpuClkEn_q <= sysEn &&
                       (mode_q == clkgen_pkg::MODE_ACTIVE);
         ioHold_q   <= (mode_q == clkgen_pkg::MODE_SUBSLEEP);
      end
   end

   genvar m;
   generate
      for (m = 0; m < MOD_COUNT; m++) begin : g_mod
         always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
               periphClkEn_q[m] <= 1'b0;
               periphTick_q[m]  <= 1'b0;
            end else begin
               periphClkEn_q[m] <= sysEn & periphRun &
                                   ~modStby_q[m];
               periphTick_q[m]  <= periphRun & ~modStby_q[m] &
                                   tapOf(tapSel_q[m*SW +: SW],
                                         presc.tapPulse);
            end
         end
      end
   endgenerate

   // outputs
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end

   assign hrdata      = hrdata_q;
   assign sysClkEn    = sysClkEn_q;
   assign cpuClkEn    = cpuClkEn_q;
   assign periphClkEn = periphClkEn_q;
   assign periphTick  = periphTick_q;
   assign ioHold      = ioHold_q;

endmodule : sysclk_ctrl
`default_nettype wire

/* File: testbench/clkgen_sva.sv */
// port checker for the clock and power mode block
`timescale 1ns/1ps
`default_nettype none
module clkgen_sva #(
   parameter int unsigned MOD_COUNT = clkgen_pkg::MAX_MODULES
) (
   input wire logic                 clk,
   input wire logic                 arst_n,
   input wire logic                 hsel,
   input wire logic [31:0]          haddr,
   input wire logic [1:0]           htrans,
   input wire logic                 hwrite,
   input wire logic [2:0]           hsize,
   input wire logic [31:0]          hwdata,
   input wire logic                 hready,
   input wire logic                 hreadyout,
   input wire logic                 hresp,
   input wire logic [31:0]          hrdata,
   input wire logic                 sleepReq,
   input wire logic                 wakeReq,
   input wire logic                 sysClkEn,
   input wire logic                 cpuClkEn,
   input wire logic [MOD_COUNT-1:0] periphClkEn,
   input wire logic [MOD_COUNT-1:0] periphTick,
   input wire logic                 ioHold
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!arst_n);

   // a running cpu clock proves active mode, so the request is honoured
   sequence sleepTaken;
      sleepReq && cpuClkEn && !$past(sleepReq);
   endsequence
   sequence cpuHalted;
      ##2 !cpuClkEn;
   endsequence

   chk_periph_sys: assert property (
      (periphClkEn & ~{MOD_COUNT{sysClkEn}}) == '0)
      else $error("peripheral enable without system clock");
   chk_tick_gated: assert property ((periphTick & ~periphClkEn) == '0)
      else $error("tick on a halted module");
   chk_tick_spacing: assert property (
      periphTick != '0 |=> (periphTick & $past(periphTick)) == '0)
      else $error("tick faster than half the system clock");
   chk_hold_quiet: assert property (
      ioHold |-> !sysClkEn && !cpuClkEn && periphClkEn == '0)
      else $error("clocks running while ports held");
   chk_reset_start: assert property (
      $rose(arst_n) |=> sysClkEn && cpuClkEn && periphClkEn == '1)
      else $error("clocks not running after reset");
   chk_sleep_cpu_off: assert property (sleepTaken |-> cpuHalted)
      else $error("cpu clock still on after sleep");
   chk_bus_okay: assert property (hreadyout && !hresp)
      else $error("bus wait or error response");
   chk_rdata_hold: assert property (
      !(hsel && htrans[1] && hready && !hwrite) |=> $stable(hrdata))
      else $error("read data changed without a read");
endmodule : clkgen_sva
bind sysclk_ctrl clkgen_sva #(.MOD_COUNT(MOD_COUNT)) i_sva (.*);
`default_nettype wire

/* File: testbench/clk_sink.sv */
// counting sink standing for the cpu and peripheral modules
`timescale 1ns/1ps
`default_nettype none
module clk_sink #(
   parameter int N = 8
) (
   input  wire logic         clk,
   input  wire logic         cpuEn,
   input  wire logic [N-1:0] perEn,
   input  wire logic [N-1:0] tick,
   output var int            cpuCnt,
   output var int            perCnt [N],
   output var int            tickCnt [N]
);
   // counts only: the receiving modules never answer the clock block
   initial begin
      cpuCnt = 0;
      perCnt = '{default: 0};
      tickCnt = '{default: 0};
   end
   always @(posedge clk) begin
      cpuCnt <= cpuCnt + int'(cpuEn);
      for (int m = 0; m < N; m++) begin
         perCnt[m] <= perCnt[m] + int'(perEn[m]);
         tickCnt[m] <= tickCnt[m] + int'(tick[m]);
      end
   end
endmodule : clk_sink
`default_nettype wire

/* File: testbench/sysclk_prescaler_power_modes_tb.sv */
// self-checking bench for the clock and power mode block
`timescale 1ns/1ps
`default_nettype none
module sysclk_prescaler_power_modes_tb;
   logic        clk = 1'b0;
   logic        arst_n = 1'b0;
   logic        hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [2:0]  hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic        sleepReq = 1'b0;
   logic        wakeReq = 1'b0;
   logic        hreadyout, hresp, sysClkEn, cpuClkEn, ioHold;
   logic [31:0] hrdata;
   logic [7:0]  periphClkEn, periphTick;
   int          cpuCnt, perCnt [8], tickCnt [8];
   int          c0, p0 [8], t0 [8], dCpu, dPer [8], dTick [8];
   int          errCount = 0, testsRun = 0, cycles = 0;

   always #4 clk = ~clk;

   sysclk_ctrl i_dut (
      .clk(clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .sleepReq(sleepReq), .wakeReq(wakeReq),
      .sysClkEn(sysClkEn), .cpuClkEn(cpuClkEn), .periphClkEn(periphClkEn),
      .periphTick(periphTick), .ioHold(ioHold));

   clk_sink #(.N(8)) i_sink (
      .clk(clk), .cpuEn(cpuClkEn), .perEn(periphClkEn), .tick(periphTick),
      .cpuCnt(cpuCnt), .perCnt(perCnt), .tickCnt(tickCnt));

   task automatic end_sim();
      if (errCount == 0 && testsRun > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : end_sim

   // generous ceiling: the whole sequence needs about 30300 cycles
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 60000) begin
         errCount++;
         end_sim();
      end
   end

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      testsRun++;
      if (got !== exp) begin
         errCount++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp

   task automatic ahb(input logic wr, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] rd);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      hwrite <= wr;
      htrans <= 2'h2;
      do @(posedge clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : ahb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      ahb(1'b1, a, d, x);
   endtask : wr

   task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] x;
      ahb(1'b0, a, 32'h0, x);
      cmp(x, exp);
   endtask : rdChk

   task automatic pulse(input logic toSleep);
      sleepReq <= toSleep;
      wakeReq <= !toSleep;
      @(posedge clk);
      sleepReq <= 1'b0;
      wakeReq <= 1'b0;
      repeat (3) @(posedge clk);
   endtask : pulse

   // any window of whole periods holds an exact pulse count
   task automatic window(input int w);
      c0 = cpuCnt;
      p0 = perCnt;
      t0 = tickCnt;
      repeat (w) @(posedge clk);
      dCpu = cpuCnt - c0;
      for (int m = 0; m < 8; m++) begin
         dPer[m] = perCnt[m] - p0[m];
         dTick[m] = tickCnt[m] - t0[m];
      end
   endtask : window

   task automatic t_regs();
      for (int i = 0; i < 4; i++) rdChk(8'(4 * i), 32'h0);
      for (int i = 4; i < 64; i++) begin
         wr(8'(4 * i), 32'hffffffff);
         rdChk(8'(4 * i), 32'h0);
      end
      wr(8'h00, 32'hffffffff);
      rdChk(8'h00, 32'h000000f0);
      wr(8'h04, 32'hffffffff);
      rdChk(8'h04, 32'h0000000f);
      arst_n <= 1'b0;
      repeat (3) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      rdChk(8'h00, 32'h0);
      rdChk(8'h04, 32'h0);
   endtask : t_regs

   task automatic t_taps();
      wr(8'h0c, 32'h76543210);
      wr(8'h08, 32'h00000008);
      repeat (8) @(posedge clk);
      window(256);
      for (int m = 0; m < 8; m++) begin
         cmp(dTick[m], m == 3 ? 0 : 256 >> (m + 1));
         cmp(dPer[m], m == 3 ? 0 : 256);
      end
      rdChk(8'h08, 32'h00000008);
      wr(8'h08, 32'h0);
      wr(8'h0c, 32'hfedcba98);
      repeat (8) @(posedge clk);
      window(16384);
      for (int m = 0; m < 8; m++) begin
         cmp(dTick[m], m > 3 ? 2 : 16384 >> (m + 9));
      end
   endtask : t_taps

   task automatic t_div();
      int r [6] = '{1, 8, 16, 32, 64, 64};
      logic [31:0] c [6] = '{32'h0, 32'h1, 32'h2, 32'h3, 32'h4, 32'h7};
      wr(8'h0c, 32'h0);
      for (int i = 0; i < 6; i++) begin
         wr(8'h04, c[i]);
         repeat (64) @(posedge clk);
         window(512);
         cmp(dCpu, 512 / r[i]);
         cmp(dTick[0], 256 / r[i]);
      end
      wr(8'h04, 32'h0);
   endtask : t_div

   task automatic t_sleep();
      wr(8'h00, 32'h0);
      pulse(1'b1);
      rdChk(8'h10, 32'h1);
      window(64);
      cmp(dCpu, 32'h0);
      cmp(dPer[1], 32'd64);
      pulse(1'b0);
      rdChk(8'h10, 32'h0);
   endtask : t_sleep

   task automatic t_stby(input logic [2:0] sel, input int n, input logic sub);
      wr(8'h00, {24'h0, 1'b1, sel, 4'h0});
      wr(8'h04, {28'h0, sub, 3'h0});
      pulse(1'b1);
      rdChk(8'h10, sub ? 32'h3 : 32'h2);
      window(64);
      cmp(dCpu + dPer[0], 32'h0);
      cmp(dTick[0], 32'h0);
      cmp({31'h0, ioHold}, {31'h0, sub});
      wakeReq <= 1'b1;
      @(posedge clk);
      wakeReq <= 1'b0;
      repeat (n + 1) @(posedge clk);
      cmp({31'h0, cpuClkEn}, 32'h0);
      @(posedge clk);
      cmp({31'h0, cpuClkEn}, 32'h1);
      wr(8'h00, 32'h0);
      wr(8'h04, 32'h0);
   endtask : t_stby

   initial begin
      repeat (12) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      t_regs();
      t_taps();
      t_div();
      t_sleep();
      t_stby(3'h0, 8192, 1'b0);
      t_stby(3'h7, 16, 1'b0);
      t_stby(3'h6, 128, 1'b0);
      t_stby(3'h5, 1024, 1'b0);
      t_stby(3'h7, 16, 1'b1);
      end_sim();
   end
endmodule : sysclk_prescaler_power_modes_tb
`default_nettype wire
